// ### common/fftc_pkg.sv
// Purpose: Shared constants and types of the 64-point complex transform core.
// Assumes: 32-bit Avalon-MM register bus, byte addresses, one clock domain.
// Notes: Behaviour
// Behaviour
// - Forward or inverse DFT of exactly 64 complex samples.
// - Input real and imaginary parts are 16-bit two's complement each.
// - Each of the 64 results carries 16-bit real and imaginary parts.
// - Radix-4 DIF: three passes of sixteen four-point butterflies.
// - Each butterfly reads four words and writes results back in place.
// - Twiddle factors are produced inside the core at 16-bit precision.
// - Every pass divides butterfly results by four before write-back.
// - Total scaling is 1/64 with scale select low, 1/128 with it high.
// - Scale select high adds one right shift on the first pass write only.
// - Scale select acts identically for forward and inverse transforms.
// - Inverse uses the positive-exponent kernel; built-in scaling gives 1/N with scale select low.
// - Core makes all sample memory addresses, enables and write controls.
// - Three selectable memory and I/O configurations are supported.
// - In multi-bank modes loading overlaps transforming or output; only triple mode overlaps all three.
// - Input accepted and results delivered in natural index order.
// - Rising-edge clocked; core reset returns the core to idle.
// - Engine and framing state advance only on cycles where clock enable is high.
// - Direction high means forward, low inverse; sampled at start.
// - Overflow flag clears on reset, on start, at next result vector.
// - Completion pulse is one cycle at the end of the result frame.
// - Early completion pulse is one cycle right before the result frame.
package fftc_pkg;
  localparam int PTS_W = 6;
  localparam int SAMPLE_W = 16;
  localparam logic [6:0] LAST_SAMPLE = 7'h3F;
  localparam logic [1:0] LAST_PASS = 2'h2;
  localparam logic [3:0] LAST_BFLY = 4'hF;
  // Register byte offsets.
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_DIN = 4'h8;
  localparam logic [3:0] REG_DOUT = 4'hC;
  // Control register fields.
  localparam int CTRL_START = 0;
  localparam int CTRL_DIR = 1;
  localparam int CTRL_SCALE = 2;
  localparam int CTRL_CE = 3;
  localparam int CTRL_CRST = 4;
  localparam int CTRL_MODE = 5;
  localparam logic CTRL_DIR_RST = 1'b1;
  localparam logic CTRL_SCALE_RST = 1'b0;
  localparam logic CTRL_CE_RST = 1'b1;
  // Status register fields.
  localparam int ST_BUSY = 0;
  localparam int ST_RESULT = 1;
  localparam int ST_OVF = 2;
  localparam int ST_FULL = 3;
  localparam int ST_CNT = 4;
  // Memory configurations.
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_DUAL = 2'h1;
  localparam logic [1:0] MODE_TRIPLE = 2'h2;
  localparam logic [1:0] BANK_RST = 2'h0;
  // Fixed-point scaling.
  localparam logic [4:0] TWID_FRAC = 5'h0F;
  localparam logic [4:0] PASS_SHIFT = 5'h02;
  localparam logic [4:0] EXTRA_SHIFT = 5'h01;
  typedef enum logic [1:0] {E_IDLE = 2'b00, E_READ = 2'b01, E_WRITE = 2'b11} fftc_eng_state_t;
  typedef enum logic [1:0] {
    O_IDLE = 2'b00, O_EARLY = 2'b01, O_FRAME = 2'b11, O_DONE = 2'b10
  } fftc_out_state_t;
endpackage

// ### common/fftc_bfly_if.sv
// Purpose: Carries one butterfly operand set and its results.
// Assumes: Purely combinational path between the core and the butterfly.
// Notes: Words hold imaginary in bits 31:16 and real in bits 15:0.
`timescale 1ns/1ps
`default_nettype none
interface fftc_bfly_if;
  logic [3:0][31:0] x;
  logic [3:0][31:0] y;
  logic [5:0] step;
  logic inverse;
  logic extra_shift;
  logic ovf;
  modport core (output x, output step, output inverse, output extra_shift, input y, input ovf);
  modport engine (input x, input step, input inverse, input extra_shift, output y, output ovf);
endinterface
`default_nettype wire

// ### hdl/fftc_butterfly.sv
// Purpose: Combinational radix-4 DIF butterfly with twiddle and scaling.
// Assumes: Twiddle exponent of output m is step times m, modulo 64.
// Notes: Results truncate toward minus infinity and saturate on overflow.
`timescale 1ns/1ps
`default_nettype none
module fftc_butterfly (
  // Operands and results.
  fftc_bfly_if.engine bf
);
  // Cosine of 2*pi*r/64 in Q15 for the first quarter.
  function automatic logic [15:0] cos_tab(input logic [4:0] r);
    case (r)
      5'h00: cos_tab = 16'h7FFF;
      5'h01: cos_tab = 16'h7F61;
      5'h02: cos_tab = 16'h7D89;
      5'h03: cos_tab = 16'h7A7C;
      5'h04: cos_tab = 16'h7641;
      5'h05: cos_tab = 16'h70E2;
      5'h06: cos_tab = 16'h6A6D;
      5'h07: cos_tab = 16'h62F1;
      5'h08: cos_tab = 16'h5A82;
      5'h09: cos_tab = 16'h5133;
      5'h0A: cos_tab = 16'h471C;
      5'h0B: cos_tab = 16'h3C56;
      5'h0C: cos_tab = 16'h30FB;
      5'h0D: cos_tab = 16'h2528;
      5'h0E: cos_tab = 16'h18F9;
      5'h0F: cos_tab = 16'h0C8C;
      default: cos_tab = 16'h0000;
    endcase
  endfunction

  // Twiddle as {imag, real}; forward uses exp(-j), inverse exp(+j).
  function automatic logic [31:0] twiddle(input logic [5:0] e, input logic inv);
    logic [15:0] c0;
    logic [15:0] c1;
    logic [15:0] c;
    logic [15:0] s;
    c0 = cos_tab({1'b0, e[3:0]});
    c1 = cos_tab(5'h10 - {1'b0, e[3:0]});
    case (e[5:4])
      2'h0: begin c = c0; s = c1; end
      2'h1: begin c = -c1; s = c0; end
      2'h2: begin c = -c0; s = -c1; end
      default: begin c = c1; s = -c0; end
    endcase
    twiddle = {(inv ? s : -s), c};
  endfunction

  // Clamps a wide scaled value to 16 bits.
  function automatic logic [15:0] sat16(input logic signed [34:0] v);
    if (&v[34:15] || ~|v[34:15])
      sat16 = v[15:0];
    else
      sat16 = v[34] ? 16'h8000 : 16'h7FFF;
  endfunction

  logic signed [17:0] ar, ai, br, bi, cr, ci, dr, di;
  logic [3:0][17:0] sr;
  logic [3:0][17:0] si;
  logic [3:0] ovf_vec;
  logic [4:0] shift;

  // Widen operands so the four-term sums cannot wrap.
  assign ar = 18'($signed(bf.x[0][15:0]));
  assign ai = 18'($signed(bf.x[0][31:16]));
  assign br = 18'($signed(bf.x[1][15:0]));
  assign bi = 18'($signed(bf.x[1][31:16]));
  assign cr = 18'($signed(bf.x[2][15:0]));
  assign ci = 18'($signed(bf.x[2][31:16]));
  assign dr = 18'($signed(bf.x[3][15:0]));
  assign di = 18'($signed(bf.x[3][31:16]));
  assign shift = TWID_SHIFT();

  function automatic logic [4:0] TWID_SHIFT();
    TWID_SHIFT = fftc_pkg::TWID_FRAC + fftc_pkg::PASS_SHIFT;
  endfunction

  // Four-point DFT; the inverse swaps the j-rotated outputs.
  always_comb
  begin
    sr[0] = ar + br + cr + dr;
    si[0] = ai + bi + ci + di;
    sr[2] = ar - br + cr - dr;
    si[2] = ai - bi + ci - di;
    sr[1] = bf.inverse ? (ar - bi - cr + di) : (ar + bi - cr - di);
    si[1] = bf.inverse ? (ai + br - ci - dr) : (ai - br - ci + dr);
    sr[3] = bf.inverse ? (ar + bi - cr - di) : (ar - bi - cr + di);
    si[3] = bf.inverse ? (ai - br - ci + dr) : (ai + br - ci - dr);
  end

  // Per output: twiddle multiply, scale, then truncate once.
  for (genvar m = 0; m < 4; m++)
  begin : g_out
    logic [31:0] w;
    logic signed [34:0] pr;
    logic signed [34:0] pi;
    logic signed [34:0] qr;
    logic signed [34:0] qi;
    logic [4:0] sh;
    assign w = twiddle(6'(bf.step * 6'(m)), bf.inverse);
    assign pr = 35'($signed(sr[m]) * $signed(w[15:0])) - 35'($signed(si[m]) * $signed(w[31:16]));
    assign pi = 35'($signed(sr[m]) * $signed(w[31:16])) + 35'($signed(si[m]) * $signed(w[15:0]));
    assign sh = bf.extra_shift ? shift + fftc_pkg::EXTRA_SHIFT : shift;
    assign qr = pr >>> sh;
    assign qi = pi >>> sh;
    assign bf.y[m] = {sat16(qi), sat16(qr)};
    assign ovf_vec[m] = (sat16(qr) != qr[15:0]) || (sat16(qi) != qi[15:0]);
  end
  assign bf.ovf = |ovf_vec;
endmodule
`default_nettype wire

// ### hdl/fftc_core.sv
// Purpose: 64-point complex forward/inverse transform core with Avalon-MM access.
// Assumes: Synchronous single clock; software feeds and drains samples by registers.
// Notes: Three sample banks; the memory configuration decides how they rotate.
//
// The register offsets and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module fftc_core (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Avalon-MM slave.
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Result framing and status.
  output logic result_valid_o,
  output logic done_o,
  output logic early_complete_pulse_o,
  output logic arith_overflow_flag_o
);
  typedef struct packed {
    logic [2:0][63:0][31:0] mem;
    fftc_pkg::fftc_eng_state_t est;
    fftc_pkg::fftc_out_state_t ost;
    logic [1:0] pass;
    logic [3:0] bfly;
    logic [3:0][31:0] x;
    logic dir;
    logic scl;
    logic [1:0] in_bank;
    logic [1:0] work_bank;
    logic [1:0] res_bank;
    logic [1:0] out_bank;
    logic [6:0] in_cnt;
    logic in_full;
    logic [5:0] out_cnt;
    logic res_pend;
    logic ovf;
    logic ctl_dir;
    logic ctl_scl;
    logic ctl_ce;
    logic [1:0] ctl_mode;
    logic start_req;
    logic rack;
    logic [31:0] rdata;
  } fftc_state_t;

  fftc_state_t s_reg;
  fftc_state_t s_next;
  fftc_bfly_if bf_if ();

  logic is_ctrl;
  logic is_status;
  logic is_din;
  logic is_dout;
  logic din_stall;
  logic dout_hold;
  logic wr_ok;
  logic rd_take;
  logic core_rst;
  logic start_ok;
  logic [1:0] nb;

  // Butterfly location inside the 64 words for pass, butterfly and leg.
  function automatic logic [5:0] bfly_addr(input logic [1:0] p, input logic [3:0] b,
                                           input logic [1:0] k);
    case (p)
      2'h0: bfly_addr = {k, b};
      2'h1: bfly_addr = {b[3:2], k, b[1:0]};
      default: bfly_addr = {b, k};
    endcase
  endfunction

  // Twiddle step of a butterfly: its position in the group times 4^pass.
  function automatic logic [5:0] twid_step(input logic [1:0] p, input logic [3:0] b);
    case (p)
      2'h0: twid_step = {2'h0, b};
      2'h1: twid_step = {b[1:0], 2'h0};
      default: twid_step = 6'h00;
    endcase
  endfunction

  // Base-4 digit reversal that restores natural result order.
  function automatic logic [5:0] digit_rev(input logic [5:0] i);
    digit_rev = {i[1:0], i[3:2], i[5:4]};
  endfunction

  // Bank that receives the next input vector in each configuration.
  function automatic logic [1:0] next_bank(input logic [1:0] mode, input logic [1:0] b);
    case (mode)
      fftc_pkg::MODE_DUAL: next_bank = {1'b0, ~b[0]};
      fftc_pkg::MODE_TRIPLE: next_bank = (b == 2'h2) ? 2'h0 : b + 2'h1;
      default: next_bank = b;
    endcase
  endfunction

  fftc_butterfly u_bfly (
    .bf(bf_if)
  );

  // Operands to the butterfly come from the latched legs.
  assign bf_if.x = s_reg.x;
  assign bf_if.step = twid_step(s_reg.pass, s_reg.bfly);
  assign bf_if.inverse = ~s_reg.dir;
  assign bf_if.extra_shift = s_reg.scl && (s_reg.pass == 2'h0);

  // Address decode and bus stalls.
  assign is_ctrl = (avs_address_i == fftc_pkg::REG_CTRL);
  assign is_status = (avs_address_i == fftc_pkg::REG_STATUS);
  assign is_din = (avs_address_i == fftc_pkg::REG_DIN);
  assign is_dout = (avs_address_i == fftc_pkg::REG_DOUT);
  assign nb = next_bank(s_reg.ctl_mode, s_reg.in_bank);
  // Input words wait while their bank is full or owned by the engine or the output.
  assign din_stall = ~s_reg.ctl_ce || s_reg.in_full ||
                     (s_reg.est != fftc_pkg::E_IDLE && s_reg.in_bank == s_reg.work_bank) ||
                     (s_reg.ost != fftc_pkg::O_IDLE && s_reg.in_bank == s_reg.out_bank) ||
                     (s_reg.res_pend && s_reg.in_bank == s_reg.res_bank);
  assign dout_hold = is_dout && ~s_reg.ctl_ce;
  assign avs_waitrequest_o = (avs_write_i && is_din && din_stall) ||
                             (avs_read_i && ~s_reg.rack);
  assign wr_ok = avs_write_i && ~avs_read_i && ~avs_waitrequest_o;
  assign rd_take = avs_read_i && ~s_reg.rack && ~dout_hold;
  assign core_rst = wr_ok && is_ctrl && avs_byteenable_i[0] &&
                    avs_writedata_i[fftc_pkg::CTRL_CRST];
  // A transform may start once a full vector waits and no result is pending.
  assign start_ok = s_reg.in_full && ~s_reg.res_pend &&
                    (s_reg.start_req || s_reg.ctl_mode != fftc_pkg::MODE_SINGLE) &&
                    ~(s_reg.ost != fftc_pkg::O_IDLE && nb == s_reg.out_bank &&
                      s_reg.ctl_mode != fftc_pkg::MODE_SINGLE) &&
                    ~(s_reg.ost != fftc_pkg::O_IDLE &&
                      s_reg.ctl_mode == fftc_pkg::MODE_SINGLE);

  // Next-state logic for the bus, output framing and the engine.
  always_comb
  begin
    s_next = s_reg;
    s_next.rack = rd_take;
    // Read capture; status reflects live core state.
    if (rd_take)
    begin
      s_next.rdata = 32'h0000_0000;
      if (is_ctrl)
      begin
        s_next.rdata[fftc_pkg::CTRL_DIR] = s_reg.ctl_dir;
        s_next.rdata[fftc_pkg::CTRL_SCALE] = s_reg.ctl_scl;
        s_next.rdata[fftc_pkg::CTRL_CE] = s_reg.ctl_ce;
        s_next.rdata[fftc_pkg::CTRL_MODE +: 2] = s_reg.ctl_mode;
      end
      else if (is_status)
      begin
        s_next.rdata[fftc_pkg::ST_BUSY] = (s_reg.est != fftc_pkg::E_IDLE);
        s_next.rdata[fftc_pkg::ST_RESULT] = (s_reg.ost == fftc_pkg::O_FRAME);
        s_next.rdata[fftc_pkg::ST_OVF] = s_reg.ovf;
        s_next.rdata[fftc_pkg::ST_FULL] = s_reg.in_full;
        s_next.rdata[fftc_pkg::ST_CNT +: 7] = s_reg.in_cnt;
      end
      else if (is_dout && s_reg.ost == fftc_pkg::O_FRAME)
      begin
        s_next.rdata = s_reg.mem[s_reg.out_bank][digit_rev(s_reg.out_cnt)];
        s_next.out_cnt = s_reg.out_cnt + 6'h01;
        if (s_reg.out_cnt == fftc_pkg::LAST_SAMPLE[5:0])
          s_next.ost = fftc_pkg::O_DONE;
      end
    end
    // Control writes; start is held until the engine can take it.
    if (wr_ok && is_ctrl && avs_byteenable_i[0])
    begin
      s_next.ctl_dir = avs_writedata_i[fftc_pkg::CTRL_DIR];
      s_next.ctl_scl = avs_writedata_i[fftc_pkg::CTRL_SCALE];
      s_next.ctl_ce = avs_writedata_i[fftc_pkg::CTRL_CE];
      s_next.ctl_mode = avs_writedata_i[fftc_pkg::CTRL_MODE +: 2];
    end
    // Input samples land in natural order in the input bank.
    if (wr_ok && is_din)
    begin
      s_next.mem[s_reg.in_bank][s_reg.in_cnt[5:0]] = avs_writedata_i;
      s_next.in_cnt = s_reg.in_cnt + 7'h01;
      s_next.in_full = (s_reg.in_cnt == fftc_pkg::LAST_SAMPLE);
    end
    // Framing and engine below move only on enabled cycles; the start request and core reset after them do not wait for it.
    if (s_reg.ctl_ce)
    begin
      // Output framing: early pulse, frame, then completion pulse.
      case (s_reg.ost)
        fftc_pkg::O_IDLE:
        begin
          if (s_reg.res_pend)
          begin
            s_next.ost = fftc_pkg::O_EARLY;
            s_next.out_bank = s_reg.res_bank;
            s_next.out_cnt = 6'h00;
            s_next.res_pend = 1'b0;
          end
        end
        fftc_pkg::O_EARLY:
        begin
          s_next.ost = fftc_pkg::O_FRAME;
          s_next.ovf = 1'b0;
        end
        fftc_pkg::O_FRAME:
        begin
          s_next.ost = s_next.ost;
        end
        fftc_pkg::O_DONE:
        begin
          s_next.ost = fftc_pkg::O_IDLE;
        end
        default:
        begin
          s_next.ost = fftc_pkg::O_IDLE;
        end
      endcase
      // Engine: three passes of sixteen read/write butterfly steps.
      case (s_reg.est)
        fftc_pkg::E_IDLE:
        begin
          if (start_ok)
          begin
            s_next.dir = s_reg.ctl_dir;
            s_next.scl = s_reg.ctl_scl;
            s_next.work_bank = s_reg.in_bank;
            s_next.in_bank = nb;
            s_next.in_cnt = 7'h00;
            s_next.in_full = 1'b0;
            s_next.pass = 2'h0;
            s_next.bfly = 4'h0;
            s_next.start_req = 1'b0;
            s_next.ovf = 1'b0;
            s_next.est = fftc_pkg::E_READ;
          end
        end
        fftc_pkg::E_READ:
        begin
          for (int k = 0; k < 4; k++)
            s_next.x[k] = s_reg.mem[s_reg.work_bank][bfly_addr(s_reg.pass, s_reg.bfly, 2'(k))];
          s_next.est = fftc_pkg::E_WRITE;
        end
        fftc_pkg::E_WRITE:
        begin
          for (int k = 0; k < 4; k++)
            s_next.mem[s_reg.work_bank][bfly_addr(s_reg.pass, s_reg.bfly, 2'(k))] =
              bf_if.y[k];
          if (bf_if.ovf)
            s_next.ovf = 1'b1;
          s_next.est = fftc_pkg::E_READ;
          s_next.bfly = s_reg.bfly + 4'h1;
          if (s_reg.bfly == fftc_pkg::LAST_BFLY)
          begin
            s_next.pass = s_reg.pass + 2'h1;
            if (s_reg.pass == fftc_pkg::LAST_PASS)
            begin
              s_next.est = fftc_pkg::E_IDLE;
              s_next.res_pend = 1'b1;
              s_next.res_bank = s_reg.work_bank;
            end
          end
        end
        default:
        begin
          s_next.est = fftc_pkg::E_IDLE;
        end
      endcase
    end
    // A new start request is never lost to the consuming clear.
    if (wr_ok && is_ctrl && avs_byteenable_i[0] && avs_writedata_i[fftc_pkg::CTRL_START])
      s_next.start_req = 1'b1;
    // Core reset returns engine, framing and counters to idle.
    if (core_rst)
    begin
      s_next.est = fftc_pkg::E_IDLE;
      s_next.ost = fftc_pkg::O_IDLE;
      s_next.in_cnt = 7'h00;
      s_next.in_full = 1'b0;
      s_next.res_pend = 1'b0;
      s_next.ovf = 1'b0;
      s_next.start_req = 1'b0;
      s_next.in_bank = fftc_pkg::BANK_RST;
      s_next.work_bank = fftc_pkg::BANK_RST;
      s_next.out_bank = fftc_pkg::BANK_RST;
      s_next.res_bank = fftc_pkg::BANK_RST;
    end
  end

  // State register; reset clears the sample memory as well.
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      s_reg.mem <= '0;
      s_reg.est <= fftc_pkg::E_IDLE;
      s_reg.ost <= fftc_pkg::O_IDLE;
      s_reg.pass <= 2'h0;
      s_reg.bfly <= 4'h0;
      s_reg.x <= '0;
      s_reg.dir <= fftc_pkg::CTRL_DIR_RST;
      s_reg.scl <= fftc_pkg::CTRL_SCALE_RST;
      s_reg.in_bank <= fftc_pkg::BANK_RST;
      s_reg.work_bank <= fftc_pkg::BANK_RST;
      s_reg.res_bank <= fftc_pkg::BANK_RST;
      s_reg.out_bank <= fftc_pkg::BANK_RST;
      s_reg.in_cnt <= 7'h00;
      s_reg.in_full <= 1'b0;
      s_reg.out_cnt <= 6'h00;
      s_reg.res_pend <= 1'b0;
      s_reg.ovf <= 1'b0;
      s_reg.ctl_dir <= fftc_pkg::CTRL_DIR_RST;
      s_reg.ctl_scl <= fftc_pkg::CTRL_SCALE_RST;
      s_reg.ctl_ce <= fftc_pkg::CTRL_CE_RST;
      s_reg.ctl_mode <= fftc_pkg::MODE_SINGLE;
      s_reg.start_req <= 1'b0;
      s_reg.rack <= 1'b0;
      s_reg.rdata <= 32'h0000_0000;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // Outputs taken from registered state.
  assign avs_readdata_o = s_reg.rdata;
  assign result_valid_o = (s_reg.ost == fftc_pkg::O_FRAME);
  assign done_o = (s_reg.ost == fftc_pkg::O_DONE);
  assign early_complete_pulse_o = (s_reg.ost == fftc_pkg::O_EARLY);
  assign arith_overflow_flag_o = s_reg.ovf;
endmodule
`default_nettype wire

// ### testbench/fftc_core_asserts.sv
// Purpose: Bus and result framing checks of the transform core.
// Assumes: One clock, reset active low.
// Notes: The clock enable bit is mirrored from accepted control writes.
`timescale 1ns/1ps
`default_nettype none
module fftc_core_asserts (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Register bus.
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Framing.
  input wire logic result_valid_o,
  input wire logic done_o,
  input wire logic early_complete_pulse_o,
  input wire logic arith_overflow_flag_o
);
  logic ce_reg;
  logic ctl_wr;
  logic dout_ack;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  // Accepted control writes and result reads at their capture edge.
  assign ctl_wr = avs_write_i && !avs_read_i && !avs_waitrequest_o && avs_byteenable_i[0]
    && avs_address_i == fftc_pkg::REG_CTRL;
  assign dout_ack = avs_read_i && avs_waitrequest_o && avs_address_i == fftc_pkg::REG_DOUT;
  // Mirror of the clock enable bit, needed because pulses stretch while it is low.
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      ce_reg <= fftc_pkg::CTRL_CE_RST;
    else if (ctl_wr)
      ce_reg <= avs_writedata_i[fftc_pkg::CTRL_CE];
  end
  a_early_one: assert property (early_complete_pulse_o && ce_reg |=> !early_complete_pulse_o)
    else $error("early pulse too long");
  a_early_frame: assert property (early_complete_pulse_o && ce_reg && !ctl_wr |=> result_valid_o)
    else $error("frame missing after early pulse");
  a_frame_cause: assert property ($rose(result_valid_o) |-> $past(early_complete_pulse_o))
    else $error("frame without early pulse");
  a_done_one: assert property (done_o && ce_reg |=> !done_o)
    else $error("done pulse too long");
  a_done_cause: assert property ($rose(done_o) |-> $past(result_valid_o))
    else $error("done without frame");
  a_frame_end: assert property ($fell(result_valid_o) |-> $past(dout_ack) || $past(ctl_wr))
    else $error("frame ended without read");
  a_soft_reset: assert property (ctl_wr && avs_writedata_i[fftc_pkg::CTRL_CRST] |=>
    !result_valid_o && !early_complete_pulse_o && !arith_overflow_flag_o)
    else $error("soft reset left state");
  a_read_wait: assert property ($rose(avs_read_i) && avs_address_i != fftc_pkg::REG_DOUT
    |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("read wait state wrong");
  a_frame_excl: assert property (!(result_valid_o && (early_complete_pulse_o || done_o)))
    else $error("pulse inside frame");
  a_ctl_nowait: assert property (avs_write_i && !avs_read_i
    && avs_address_i == fftc_pkg::REG_CTRL |-> !avs_waitrequest_o)
    else $error("control write stalled");
  c_early: cover property (early_complete_pulse_o);
  c_done: cover property (done_o);
  c_soft: cover property (ctl_wr && avs_writedata_i[fftc_pkg::CTRL_CRST] && result_valid_o);
endmodule
bind fftc_core fftc_core_asserts i_chk (.clk_sys_i, .reset_n_i, .avs_address_i, .avs_read_i,
  .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
  .result_valid_o, .done_o, .early_complete_pulse_o, .arith_overflow_flag_o);
`default_nettype wire

// ### testbench/fftc_user_model.sv
// Purpose: User logic that feeds vectors and drains results over the bus.
// Assumes: Bus master changes signals only just after a rising edge.
// Notes: Every wait is bounded; n_to counts waits that ran out.
`timescale 1ns/1ps
`default_nettype none
module fftc_user_model (
  // Clock and slave answers.
  input wire logic clk_i,
  input wire logic [31:0] rdata_i,
  input wire logic wait_i,
  // Requests.
  output logic [3:0] adr_o,
  output logic rd_o,
  output logic wr_o,
  output logic [31:0] wdata_o,
  output logic [3:0] be_o
);
  int n_to = 0;
  // Idle bus at time zero.
  initial
  begin
    adr_o = 4'h0;
    rd_o = 1'h0;
    wr_o = 1'h0;
    wdata_o = 32'h0;
    be_o = 4'hF;
  end
  // Waits for the edge at which waitrequest is sampled low.
  task automatic wait_ack();
    int n;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wait_i && n < 500);
    if (wait_i)
      n_to++;
  endtask
  // One write, synchronous to the clock.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    adr_o <= a;
    wdata_o <= d;
    wr_o <= 1'h1;
    wait_ack();
    wr_o <= 1'h0;
  endtask
  // One read; data are taken at the acknowledging edge.
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_i);
    adr_o <= a;
    rd_o <= 1'h1;
    wait_ack();
    d = rdata_i;
    rd_o <= 1'h0;
  endtask
  // Loads a vector in index order holding one real impulse at index one.
  task automatic load_impulse(input logic [15:0] c);
    for (int i = 0; i < 64; i++)
      wr(fftc_pkg::REG_DIN, (i == 1) ? {16'h0000, c} : 32'h0);
  endtask
endmodule
`default_nettype wire

// ### testbench/fft64_radix4_transform_core_tb.sv
// Purpose: Self-checking bench of the transform core.
// Assumes: An impulse at index one gives known bins 0, 16, 32 and 48.
// Notes: Result bins are compared with a small tolerance for truncation.
`timescale 1ns/1ps
`default_nettype none
module fft64_radix4_transform_core_tb;
  typedef struct packed {logic [31:0] ctl; logic [15:0] e0; logic [15:0] e16;} fftc_row_t;
  logic clk_sys_i = 1'h0;
  logic reset_n_i = 1'h0;
  logic [3:0] adr, be;
  logic rd, wr, wq, rv, dn, ep, ovf;
  logic [31:0] wd, rdat, d;
  logic [15:0] er, ei;
  int n_errors = 0;
  int compares = 0;
  // Forward/inverse, both scalings, single, dual and triple configurations.
  fftc_row_t rows [5] = '{'{32'h0B, 16'h0100, 16'hFF00}, '{32'h0F, 16'h0080, 16'hFF80},
    '{32'h09, 16'h0100, 16'h0100}, '{32'h2C, 16'h0080, 16'h0080},
    '{32'h4B, 16'h0100, 16'hFF00}};
  always #10 clk_sys_i = ~clk_sys_i;
  // A bus wait that timed out ends the run.
  always @(posedge clk_sys_i)
    if (i_usr.n_to != 0)
      summarize();
  fftc_core i_dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wq), .result_valid_o(rv), .done_o(dn),
    .early_complete_pulse_o(ep), .arith_overflow_flag_o(ovf));
  fftc_user_model i_usr (.clk_i(clk_sys_i), .rdata_i(rdat), .wait_i(wq), .adr_o(adr),
    .rd_o(rd), .wr_o(wr), .wdata_o(wd), .be_o(be));
  // Compares one value and reports a mismatch.
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // True when a result part lies within four steps of its expected value.
  function automatic logic near(input logic [15:0] s, input logic [15:0] e);
    logic [15:0] df;
    df = s - e;
    return (df[15] ? -df : df) <= 16'h0004;
  endfunction
  // Waits a bounded time for the early pulse (sel 0) or the done pulse (sel 1).
  task automatic wait_hi(input int sel, input int lim, input logic exp);
    int n;
    n = 0;
    while (((sel == 0) ? ep : dn) !== 1'h1 && n < lim)
    begin
      @(posedge clk_sys_i);
      n++;
    end
    check("pulse", ((sel == 0) ? ep : dn) === 1'h1, exp);
    if (exp && ((sel == 0) ? ep : dn) !== 1'h1)
      summarize();
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    n_errors += i_usr.n_to;
    $display("Comparisons %0d, errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Main sequence.
  initial
  begin
    repeat (12) @(posedge clk_sys_i);
    reset_n_i <= 1'h1;
    i_usr.rd(fftc_pkg::REG_STATUS, d);
    check("status", d, 32'h0);
    i_usr.rd(fftc_pkg::REG_CTRL, d);
    check("ctrl", d, 32'h0A);
    foreach (rows[r])
    begin
      i_usr.wr(fftc_pkg::REG_CTRL, rows[r].ctl | 32'h10);
      i_usr.wr(fftc_pkg::REG_CTRL, rows[r].ctl);
      i_usr.load_impulse(16'h4000);
      wait_hi(0, 400, 1'h1);
      check("ovf", ovf, 32'h0);
      for (int k = 0; k < 64; k++)
      begin
        i_usr.rd(fftc_pkg::REG_DOUT, d);
        er = (k == 0) ? rows[r].e0 : (k == 32) ? -rows[r].e0 : 16'h0;
        ei = (k == 16) ? rows[r].e16 : (k == 48) ? -rows[r].e16 : 16'h0;
        if (k % 16 == 0)
          check("bin", {near(d[15:0], er), near(d[31:16], ei)}, 32'h3);
      end
      wait_hi(1, 4, 1'h1);
    end
    i_usr.rd(fftc_pkg::REG_DOUT, d);
    check("dout idle", d, 32'h0);
    i_usr.rd(4'h2, d);
    check("unmapped", d, 32'h0);
    for (int i = 0; i < 3; i++)
      i_usr.wr(fftc_pkg::REG_DIN, 32'h0);
    i_usr.rd(fftc_pkg::REG_STATUS, d);
    check("count", d, 32'h30);
    i_usr.wr(fftc_pkg::REG_CTRL, 32'h1A);
    i_usr.rd(fftc_pkg::REG_STATUS, d);
    check("soft reset", d, 32'h0);
    i_usr.load_impulse(16'h4000);
    i_usr.wr(fftc_pkg::REG_CTRL, 32'h03);
    wait_hi(0, 200, 1'h0);
    i_usr.wr(fftc_pkg::REG_CTRL, 32'h0A);
    wait_hi(0, 400, 1'h1);
    i_usr.wr(fftc_pkg::REG_CTRL, 32'h1A);
    @(posedge clk_sys_i);
    check("frame", rv, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
